// ---- logic/sat_arith_pkg.sv ----
// Register map, field layout and saturation arithmetic shared by the unit
package sat_arith_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_OPA = 8'h00;
	localparam logic [7:0] ADDR_OPB = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_CMD = 8'h0C;
	localparam logic [7:0] ADDR_RESULT = 8'h10;
	localparam logic [7:0] ADDR_PSR = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h20;
	localparam logic [7:0] ADDR_LAST = 8'h24;

	// Control register fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_WIDTH_LSB = 4;
	localparam int CTRL_ARITH_BIT = 10;
	localparam int CTRL_SHAMT_LSB = 11;
	localparam int CTRL_COND_BIT = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int CMD_START_BIT = 0;

	// Program status register fields
	localparam int PSR_N_BIT = 31;
	localparam int PSR_Z_BIT = 30;
	localparam int PSR_C_BIT = 29;
	localparam int PSR_V_BIT = 28;
	localparam int PSR_Q_BIT = 27;
	localparam logic [4:0] PSR_RESET = 5'h00;

	// Interrupt status bits
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_SAT_BIT = 1;
	localparam int IRQ_ERR_BIT = 2;
	localparam int IRQ_W = 3;

	// Legal width and shift limits
	localparam logic [5:0] WORD_SMIN_N = 6'h01;
	localparam logic [5:0] WORD_SMAX_N = 6'h20;
	localparam logic [5:0] WORD_UMAX_N = 6'h1F;
	localparam logic [5:0] HALF_SMAX_N = 6'h10;
	localparam logic [5:0] HALF_UMAX_N = 6'h0F;
	localparam logic [4:0] ARITH_SHIFT_MIN = 5'h01;
	localparam logic [5:0] LANE8_N = 6'h08;
	localparam logic [5:0] LANE16_N = 6'h10;
	localparam logic [5:0] WORD_N = 6'h20;

	// Operation codes held in the control register
	typedef enum logic [3:0] {
		OP_SWIDTH,
		OP_UWIDTH,
		OP_SDUAL,
		OP_UDUAL,
		OP_ADDW,
		OP_SUBW,
		OP_ADDB,
		OP_ADDH,
		OP_SUBB,
		OP_SUBH
	} sat_op_e;

	// Clamp a wide signed value to n bits; returns {saturated, result}
	function automatic logic [32:0] sat_to_width(input logic signed [33:0] v,
		input logic [5:0] n, input logic uns);
		logic signed [33:0] hi;
		logic signed [33:0] lo;
		logic [31:0] r;
		logic s;
		if (uns) begin
			hi = (34'sh1 <<< n) - 34'sh1;
			lo = 34'sh0;
		end else begin
			hi = (34'sh1 <<< (n - 6'h01)) - 34'sh1;
			lo = -(34'sh1 <<< (n - 6'h01));
		end
		s = (v < lo) || (v > hi);
		if (v < lo) begin
			r = lo[31:0];
		end else if (v > hi) begin
			r = hi[31:0];
		end else begin
			r = v[31:0];
		end
		return {s, r};
	endfunction

endpackage

// ---- logic/sat_if.sv ----
// Link between the control unit and the shift-and-saturate engine
`timescale 1ns/100ps
interface sat_if;
	logic [31:0] operand;
	logic shiftArith;
	logic [4:0] shiftAmt;
	logic [5:0] width;
	logic unsignedMode;
	logic [31:0] result;
	logic saturated;

	modport client (output operand, shiftArith, shiftAmt, width, unsignedMode,
		input result, saturated);
	modport engine (input operand, shiftArith, shiftAmt, width, unsignedMode,
		output result, saturated);
endinterface

// ---- logic/width_saturator.sv ----
// Pre-shift and width saturation engine for the word saturate operations
`timescale 1ns/100ps
module width_saturator import sat_arith_pkg::*; (
	// Request and answer
	sat_if.engine link
);
	logic [31:0] shifted;
	logic [32:0] clamp;

	// Shift stays inside 32 bits; bits pushed out on the left are lost
	always_comb begin
		if (link.shiftArith) begin
			shifted = $signed(link.operand) >>> link.shiftAmt;
		end else begin
			shifted = link.operand << link.shiftAmt;
		end
	end

	// Signed or unsigned clamp of the shifted word
	always_comb begin
		clamp = sat_to_width({{2{shifted[31]}}, shifted}, link.width,
			link.unsignedMode);
		link.result = clamp[31:0];
		link.saturated = clamp[32];
	end

endmodule // width_saturator

// ---- logic/saturating_arith_unit.sv ----
// Saturating arithmetic datapath with APB register access
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
// Overview of operation
// - Signed saturate clamps into signed n-bit range
// - Unsigned saturate returns zero for negatives
// - Saturation sets sticky flag, else unchanged
// - Flag cleared only by status write
// - Width ranges: signed 1-32, unsigned 0-31
// - Optional pre-shift: right 1-31, left 0-31
// - Dual-half saturate each half, widths 16/15
// - Dual-half results land in matching halves
// - Word add/sub clamps to signed 32 bits
// - Lane add/sub clamps each lane separately
// - Lane add/sub never touch sticky flag
// - Condition flags never altered by operations
// - Failed condition leaves result and flags
module saturating_arith_unit import sat_arith_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt and sticky flag
	output logic irq,
	output logic satFlag
);

	// Bus state
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic accessFirst;
	logic xferDone;
	logic wrEn;

	// Software visible registers
	logic [31:0] operandA_reg;
	logic [31:0] operandB_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] result_reg;
	logic [3:0] condFlags_reg;
	logic satQ_reg;
	logic [IRQ_W-1:0] irqStat_reg;
	logic [IRQ_W-1:0] irqEn_reg;
	logic [7:0] last_reg;
	logic irq_reg;

	// Decoded control fields
	logic [3:0] opCode;
	logic [5:0] widthN;
	logic shiftArith;
	logic [4:0] shiftAmt;
	logic condPass;
	logic shiftOk;

	// Execution outcome
	logic startOp;
	logic opValid;
	logic [31:0] opResult;
	logic opSat;
	logic opTouchesQ;
	logic [32:0] laneOut;
	logic signed [33:0] wordSum;
	logic [IRQ_W-1:0] irqEvents;
	logic psrWrite;
	logic irqClrWrite;

	sat_if engLink ();

	// Is the byte address one of ours
	function automatic logic addr_mapped(input logic [7:0] a);
		return (a == ADDR_OPA) || (a == ADDR_OPB) || (a == ADDR_CTRL)
			|| (a == ADDR_CMD) || (a == ADDR_RESULT) || (a == ADDR_PSR)
			|| (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_CLR)
			|| (a == ADDR_IRQ_EN) || (a == ADDR_LAST);
	endfunction

	// Lane-wise signed add or subtract, bytes or halves
	function automatic logic [32:0] lane_arith(input logic [31:0] a,
		input logic [31:0] b, input logic byteLanes, input logic sub);
		logic signed [33:0] x;
		logic signed [33:0] y;
		logic [32:0] t;
		logic [31:0] r;
		logic s;
		r = 32'h0000_0000;
		s = 1'b0;
		x = 34'sh0;
		y = 34'sh0;
		t = 33'h0_0000_0000;
		for (int i = 0; i < 4; i++) begin
			if (byteLanes) begin
				x = {{26{a[8*i+7]}}, a[8*i+:8]};
				y = {{26{b[8*i+7]}}, b[8*i+:8]};
				t = sat_to_width(sub ? x - y : x + y, LANE8_N, 1'b0);
				r[8*i+:8] = t[7:0];
				s = s | t[32];
			end else if (i < 2) begin
				x = {{18{a[16*i+15]}}, a[16*i+:16]};
				y = {{18{b[16*i+15]}}, b[16*i+:16]};
				t = sat_to_width(sub ? x - y : x + y, LANE16_N, 1'b0);
				r[16*i+:16] = t[15:0];
				s = s | t[32];
			end
		end
		return {s, r};
	endfunction

	// Saturate both halfwords of a word independently
	function automatic logic [32:0] dual_half(input logic [31:0] a,
		input logic [5:0] n, input logic uns);
		logic [32:0] t;
		logic [31:0] r;
		logic s;
		r = 32'h0000_0000;
		s = 1'b0;
		t = 33'h0_0000_0000;
		for (int i = 0; i < 2; i++) begin
			t = sat_to_width({{18{a[16*i+15]}}, a[16*i+:16]}, n, uns);
			r[16*i+:16] = t[15:0];
			s = s | t[32];
		end
		return {s, r};
	endfunction

	// APB phase decode; every access takes one wait state
	assign accessFirst = psel & penable & ~pready_reg;
	assign xferDone = psel & penable & pready_reg;
	assign wrEn = xferDone & pwrite;
	assign startOp = wrEn && (paddr == ADDR_CMD) && pwdata[CMD_START_BIT];
	assign psrWrite = wrEn && (paddr == ADDR_PSR);
	assign irqClrWrite = wrEn && (paddr == ADDR_IRQ_CLR);

	// Control fields
	assign opCode = ctrl_reg[CTRL_OP_LSB+:4];
	assign widthN = ctrl_reg[CTRL_WIDTH_LSB+:6];
	assign shiftArith = ctrl_reg[CTRL_ARITH_BIT];
	assign shiftAmt = ctrl_reg[CTRL_SHAMT_LSB+:5];
	assign condPass = ctrl_reg[CTRL_COND_BIT];
	assign shiftOk = ~shiftArith | (shiftAmt >= ARITH_SHIFT_MIN);

	// Word saturate engine request
	assign engLink.operand = operandA_reg;
	assign engLink.shiftArith = shiftArith;
	assign engLink.shiftAmt = shiftAmt;
	assign engLink.width = widthN;
	assign engLink.unsignedMode = (opCode == OP_UWIDTH);

	width_saturator u_width_saturator (
		.link(engLink.engine)
	);

	// Full-width signed sum or difference for the word add and subtract
	always_comb begin
		if (opCode == OP_SUBW) begin
			wordSum = {{2{operandA_reg[31]}}, operandA_reg}
				- {{2{operandB_reg[31]}}, operandB_reg};
		end else begin
			wordSum = {{2{operandA_reg[31]}}, operandA_reg}
				+ {{2{operandB_reg[31]}}, operandB_reg};
		end
	end

	// Operation select; out-of-range widths or shifts are refused
	always_comb begin
		opValid = 1'b0;
		opResult = 32'h0000_0000;
		opSat = 1'b0;
		opTouchesQ = 1'b0;
		laneOut = 33'h0_0000_0000;
		unique case (opCode)
			OP_SWIDTH: begin
				opValid = (widthN >= WORD_SMIN_N) && (widthN <= WORD_SMAX_N)
					&& shiftOk;
				opResult = engLink.result;
				opSat = engLink.saturated;
				opTouchesQ = 1'b1;
			end
			OP_UWIDTH: begin
				opValid = (widthN <= WORD_UMAX_N) && shiftOk;
				opResult = engLink.result;
				opSat = engLink.saturated;
				opTouchesQ = 1'b1;
			end
			OP_SDUAL: begin
				opValid = (widthN >= WORD_SMIN_N) && (widthN <= HALF_SMAX_N);
				laneOut = dual_half(operandA_reg, widthN, 1'b0);
				opResult = laneOut[31:0];
				opSat = laneOut[32];
				opTouchesQ = 1'b1;
			end
			OP_UDUAL: begin
				opValid = (widthN <= HALF_UMAX_N);
				laneOut = dual_half(operandA_reg, widthN, 1'b1);
				opResult = laneOut[31:0];
				opSat = laneOut[32];
				opTouchesQ = 1'b1;
			end
			OP_ADDW, OP_SUBW: begin
				opValid = 1'b1;
				laneOut = sat_to_width(wordSum, WORD_N, 1'b0);
				opResult = laneOut[31:0];
				opSat = laneOut[32];
				opTouchesQ = 1'b1;
			end
			OP_ADDB, OP_SUBB: begin
				opValid = 1'b1;
				laneOut = lane_arith(operandA_reg, operandB_reg, 1'b1,
					opCode == OP_SUBB);
				opResult = laneOut[31:0];
				opSat = laneOut[32];
				opTouchesQ = 1'b0;
			end
			OP_ADDH, OP_SUBH: begin
				opValid = 1'b1;
				laneOut = lane_arith(operandA_reg, operandB_reg, 1'b0,
					opCode == OP_SUBH);
				opResult = laneOut[31:0];
				opSat = laneOut[32];
				opTouchesQ = 1'b0;
			end
			default: begin
				opValid = 1'b0;
			end
		endcase
	end

	// Bus handshake: pready rises one cycle into the access phase
	always_ff @(posedge clock) begin
		if (rst) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= accessFirst;
			pslverr_reg <= accessFirst & ~addr_mapped(paddr);
		end
	end

	// Read data captured while the access waits, so it is stable at pready
	always_ff @(posedge clock) begin
		if (rst) begin
			prdata_reg <= 32'h0000_0000;
		end else if (accessFirst && !pwrite) begin
			unique case (paddr)
				ADDR_OPA: prdata_reg <= operandA_reg;
				ADDR_OPB: prdata_reg <= operandB_reg;
				ADDR_CTRL: prdata_reg <= ctrl_reg;
				ADDR_RESULT: prdata_reg <= result_reg;
				ADDR_PSR: prdata_reg <= {condFlags_reg, satQ_reg, 27'h000_0000};
				ADDR_IRQ_STAT: prdata_reg <= {29'h0000_0000, irqStat_reg};
				ADDR_IRQ_EN: prdata_reg <= {29'h0000_0000, irqEn_reg};
				ADDR_LAST: prdata_reg <= {24'h00_0000, last_reg};
				default: prdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// Operand and control registers
	always_ff @(posedge clock) begin
		if (rst) begin
			operandA_reg <= 32'h0000_0000;
			operandB_reg <= 32'h0000_0000;
			ctrl_reg <= CTRL_RESET;
		end else if (wrEn) begin
			if (paddr == ADDR_OPA) begin
				operandA_reg <= pwdata;
			end
			if (paddr == ADDR_OPB) begin
				operandB_reg <= pwdata;
			end
			if (paddr == ADDR_CTRL) begin
				ctrl_reg <= pwdata;
			end
		end
	end

	// Destination register; a refused or condition-failed op leaves it as is
	always_ff @(posedge clock) begin
		if (rst) begin
			result_reg <= 32'h0000_0000;
		end else if (startOp && condPass && opValid) begin
			result_reg <= opResult;
		end
	end

	// Condition flags follow status writes only; operations never touch them
	always_ff @(posedge clock) begin
		if (rst) begin
			condFlags_reg <= PSR_RESET[4:1];
		end else if (psrWrite) begin
			condFlags_reg <= pwdata[PSR_V_BIT+:4];
		end
	end

	// Sticky saturation flag; a setting operation outranks a clearing write
	always_ff @(posedge clock) begin
		if (rst) begin
			satQ_reg <= PSR_RESET[0];
		end else if (startOp && condPass && opValid && opTouchesQ && opSat) begin
			satQ_reg <= 1'b1;
		end else if (psrWrite) begin
			satQ_reg <= pwdata[PSR_Q_BIT];
		end
	end

	// Summary of the last command for software diagnostics
	always_ff @(posedge clock) begin
		if (rst) begin
			last_reg <= 8'h00;
		end else if (startOp) begin
			last_reg <= {opCode, 1'b0, ~condPass, ~opValid,
				condPass & opValid & opSat};
		end
	end

	// Interrupt events of this command
	assign irqEvents[IRQ_DONE_BIT] = startOp;
	assign irqEvents[IRQ_SAT_BIT] = startOp & condPass & opValid & opSat;
	assign irqEvents[IRQ_ERR_BIT] = startOp & ~opValid;

	// Sticky interrupt status; a new event wins over a clear in the same cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			irqStat_reg <= '0;
		end else begin
			irqStat_reg <= (irqStat_reg & ~(irqClrWrite ? pwdata[IRQ_W-1:0] : '0))
				| irqEvents;
		end
	end

	// Interrupt enables and the registered interrupt line
	always_ff @(posedge clock) begin
		if (rst) begin
			irqEn_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			if (wrEn && (paddr == ADDR_IRQ_EN)) begin
				irqEn_reg <= pwdata[IRQ_W-1:0];
			end
			irq_reg <= |(irqStat_reg & irqEn_reg);
		end
	end

	// Outputs straight from flip-flops
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;
	assign satFlag = satQ_reg;

endmodule // saturating_arith_unit

// ---- tb/saturating_arith_unit_properties.sv ----
// Checker for bus timing, sticky flag and interrupt of the unit
`timescale 1ns/100ps
module saturating_arith_unit_properties import sat_arith_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Status
	input wire logic irq,
	input wire logic satFlag
);
	logic done;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Write completing at this edge
	assign done = psel && penable && pready && pwrite;
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
	a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("no ready");
	a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_unmapped_err: assert property (pready && paddr > ADDR_LAST |-> pslverr)
		else $error("unmapped access accepted");
	a_err_data: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
	a_flag_hold: assert property (!(done && (paddr == ADDR_CMD || paddr == ADDR_PSR)) |=>
		$stable(satFlag)) else $error("flag moved without cause");
	a_flag_clear: assert property ($fell(satFlag) |->
		$past(done && paddr == ADDR_PSR && !pwdata[PSR_Q_BIT])) else $error("flag cleared");
	a_irq_cause: assert property ($rose(irq) |-> $past(done, 2)) else $error("irq without write");
endmodule // saturating_arith_unit_properties

bind saturating_arith_unit saturating_arith_unit_properties u_props (.clock(clock), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .satFlag(satFlag));

// ---- tb/sat_decoder_model.sv ----
// Decoder model issuing saturate commands over the register bus
`timescale 1ns/100ps
module sat_decoder_model (
	// Clock
	input wire logic clock,
	// Answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	// Bus idle from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// One transfer: setup phase, then access phase, then wait for pready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// Wait as long as the slave needs; only the bench watchdog ends a hang
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // sat_decoder_model

// ---- tb/tb_saturating_arith_unit.sv ----
// Self-checking bench for the saturating arithmetic unit
`timescale 1ns/100ps
module tb_saturating_arith_unit import sat_arith_pkg::*;;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, irq, satFlag;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	int mismatches = 0;
	int testsRun = 0;
	// 10 MHz clock
	always #50 clock = ~clock;
	saturating_arith_unit u_saturating_arith_unit (.clock(clock), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .satFlag(satFlag));
	sat_decoder_model model (.clock(clock), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		model.xfer(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		model.xfer(1'b0, a, 32'h0, r, e);
		chk(r, exp);
	endtask
	// One command; s packs shift amount above the arithmetic-shift bit
	task automatic tc(input sat_op_e op, input logic [5:0] n, input logic [5:0] s,
		input logic [31:0] a, input logic [31:0] exp, input logic q,
		input logic [31:0] b = 32'h0, input logic cond = 1'b1);
		wr(ADDR_OPA, a);
		wr(ADDR_OPB, b);
		wr(ADDR_CTRL, {15'h0000, cond, s, n, op});
		wr(ADDR_CMD, 32'h1);
		rd(ADDR_RESULT, exp);
		chk({31'h0, satFlag}, {31'h0, q});
	endtask
	task automatic scnRegs();
		logic [31:0] r;
		logic e;
		rd(ADDR_CTRL, CTRL_RESET);
		rd(ADDR_PSR, 32'h0);
		rd(ADDR_IRQ_STAT, 32'h0);
		model.xfer(1'b0, 8'h40, 32'h0, r, e);
		chk(r, 32'h0);
		chk({31'h0, e}, 32'h1);
		wr(ADDR_RESULT, 32'h12345678);
		rd(ADDR_RESULT, 32'h0);
	endtask
	task automatic scnWidth();
		tc(OP_SWIDTH, 6'h20, 6'h00, 32'h80000000, 32'h80000000, 1'b0);
		tc(OP_UWIDTH, 6'h07, 6'h00, 32'h00000050, 32'h00000050, 1'b0);
		tc(OP_SWIDTH, 6'h08, 6'h3F, 32'h80000000, 32'hFFFFFFFF, 1'b0);
		tc(OP_SWIDTH, 6'h10, 6'h08, 32'h00001000, 32'h00007FFF, 1'b1);
		tc(OP_SWIDTH, 6'h01, 6'h00, 32'hFFFFFFFB, 32'hFFFFFFFF, 1'b1);
		wr(ADDR_PSR, 32'h0);
		// The clear lands on the edge the write ends; look one edge later
		@(posedge clock);
		chk({31'h0, satFlag}, 32'h0);
		tc(OP_SWIDTH, 6'h08, 6'h00, 32'hFFFFFF00, 32'hFFFFFF80, 1'b1);
		wr(ADDR_PSR, 32'h0);
		tc(OP_UWIDTH, 6'h00, 6'h00, 32'h00000005, 32'h00000000, 1'b1);
		tc(OP_UWIDTH, 6'h1F, 6'h00, 32'hFFFFFFFF, 32'h00000000, 1'b1);
		tc(OP_UWIDTH, 6'h1F, 6'h00, 32'h7FFFFFFF, 32'h7FFFFFFF, 1'b1);
	endtask
	task automatic scnHalf();
		wr(ADDR_PSR, 32'h0);
		tc(OP_SDUAL, 6'h10, 6'h00, 32'h7FFF8000, 32'h7FFF8000, 1'b0);
		tc(OP_SDUAL, 6'h09, 6'h00, 32'h7FFF8000, 32'h00FFFF00, 1'b1);
		wr(ADDR_PSR, 32'h0);
		tc(OP_UDUAL, 6'h0F, 6'h00, 32'h7FFF0001, 32'h7FFF0001, 1'b0);
		tc(OP_UDUAL, 6'h0F, 6'h00, 32'h80001234, 32'h00001234, 1'b1);
	endtask
	task automatic scnArith();
		wr(ADDR_PSR, 32'h0);
		tc(OP_ADDW, 6'h01, 6'h00, 32'h7FFFFFFF, 32'h7FFFFFFF, 1'b1, 32'h1);
		wr(ADDR_PSR, 32'h0);
		tc(OP_SUBW, 6'h01, 6'h00, 32'h80000000, 32'h80000000, 1'b1, 32'h1);
		wr(ADDR_PSR, 32'h0);
		tc(OP_ADDB, 6'h01, 6'h00, 32'h7F80017F, 32'h7F8002FF, 1'b0, 32'h01FF0180);
		tc(OP_ADDH, 6'h01, 6'h00, 32'h7FFF8000, 32'h7FFF8000, 1'b0, 32'h0001FFFF);
		tc(OP_SUBB, 6'h01, 6'h00, 32'h80000000, 32'h80FFFFFF, 1'b0, 32'h01010101);
		tc(OP_SUBH, 6'h01, 6'h00, 32'h80007FFF, 32'h80007FFF, 1'b0, 32'h0001FFFF);
		tc(OP_ADDW, 6'h01, 6'h00, 32'h7FFFFFFF, 32'h80007FFF, 1'b0, 32'h1, 1'b0);
		// Summary shows the word add with its condition failed
		rd(ADDR_LAST, 32'h00000044);
	endtask
	task automatic scnFlags();
		wr(ADDR_PSR, 32'hF0000000);
		tc(OP_ADDW, 6'h01, 6'h00, 32'h7FFFFFFF, 32'h7FFFFFFF, 1'b1, 32'h1);
		rd(ADDR_PSR, 32'hF8000000);
		wr(ADDR_PSR, 32'h0);
		rd(ADDR_PSR, 32'h0);
	endtask
	task automatic scnIrq();
		wr(ADDR_IRQ_CLR, 32'h7);
		wr(ADDR_IRQ_EN, 32'h1);
		tc(OP_UWIDTH, 6'h08, 6'h00, 32'h00000010, 32'h00000010, 1'b0);
		chk({31'h0, irq}, 32'h1);
		wr(ADDR_IRQ_CLR, 32'h1);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h0);
		// Masked event stays visible in status only
		wr(ADDR_IRQ_EN, 32'h0);
		tc(OP_UWIDTH, 6'h08, 6'h00, 32'h00000011, 32'h00000011, 1'b0);
		chk({31'h0, irq}, 32'h0);
		rd(ADDR_IRQ_STAT, 32'h1);
		// Width zero is refused for signed saturate
		wr(ADDR_IRQ_CLR, 32'h7);
		wr(ADDR_IRQ_EN, 32'h4);
		tc(OP_SWIDTH, 6'h00, 6'h00, 32'h00000005, 32'h00000011, 1'b0);
		chk({31'h0, irq}, 32'h1);
		rd(ADDR_LAST, 32'h00000002);
		// Arithmetic right shift by zero is refused as well
		wr(ADDR_IRQ_CLR, 32'h7);
		tc(OP_SWIDTH, 6'h08, 6'h01, 32'h00000400, 32'h00000011, 1'b0);
		rd(ADDR_IRQ_STAT, 32'h00000005);
	endtask
	task automatic tallyAndFinish();
		$display("mismatches %0d, checks %0d", mismatches, testsRun);
		if (mismatches == 0 && testsRun > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		scnRegs();
		scnWidth();
		scnHalf();
		scnArith();
		scnFlags();
		scnIrq();
		tallyAndFinish();
	end
	// Watchdog, well beyond the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		tallyAndFinish();
	end
endmodule // tb_saturating_arith_unit
